// *** hw/sbr_count_stage.sv ***
/*
  one presettable down-counting stage of the buffer address counter.
  assumes the lower stage hands in its borrow and the caller gives a one-cycle
  decrement event.
*/
`timescale 1ns/10ps
`default_nettype none

module sbr_count_stage
#(
  parameter int W = 4
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_load_val,
  input wire logic i_dec,
  input wire logic i_borrow_in,
  output logic [W-1:0] o_count,
  output logic o_borrow_out
);

  logic [W-1:0] count_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      count_r <= '0;
    else if (i_load)
      count_r <= i_load_val;
    else if (i_dec && i_borrow_in)
      count_r <= count_r - W'(1);
  end

  assign o_count = count_r;
  // borrow out only once this stage and every lower stage sit at zero
  assign o_borrow_out = i_borrow_in && (count_r == '0);

endmodule

`default_nettype wire

// *** hw/sbr_pkg.sv ***
/*
  types shared by the sector buffer ram addressing files.
  assumes nothing beyond a SystemVerilog compiler.
*/
package sbr_pkg;

  typedef struct packed {
    logic [2:0] rd;
    logic [2:0] wr;
  } sbr_fio_sel_t;

  typedef struct packed {
    logic wait_logic_enable_n;
    logic crc_initialise_n;
    logic read_gate;
    logic write_select_n;
    logic crc_word_output_ctl_n;
    logic address_mark_search;
  } sbr_func_ctl_t;

  typedef enum logic [1:0] {
    SBR_ST_IDLE = 2'h0,
    SBR_ST_ACCESS = 2'h1,
    SBR_ST_DONE = 2'h3,
    SBR_ST_HELD = 2'h2
  } sbr_state_t;

endpackage

// *** hw/sbr_regs.svh ***
/*
  named constants of the sector buffer ram addressing block: port numbers,
  field positions, reset values and timing counts.
  assumes a 40 MHz block clock; included by every design file that needs it.
*/
`ifndef SBR_REGS_SVH
`define SBR_REGS_SVH

`define SBR_ADDR_W 10
`define SBR_RAM_DEPTH 1024
`define SBR_DATA_W 8
`define SBR_ADDR_ZERO 10'h000
`define SBR_ADDR_LAST 10'h3ff
// stage layout of the cascaded counter
`define SBR_STG0_W 4
`define SBR_STG1_W 4
`define SBR_STG2_W 2
// port numbers of the fast select field
`define SBR_PORT_RAM 3'h0
`define SBR_PORT_ADDR_LO 3'h1
`define SBR_PORT_STATUS 3'h2
`define SBR_PORT_FUNC 3'h7
// function control port: bus bits 7..2, address bits 9..8 from bus bits 1..0
`define SBR_FUNC_MSB 7
`define SBR_FUNC_LSB 2
`define SBR_UPPER_MSB 1
`define SBR_UPPER_LSB 0
`define SBR_FUNC_RESET 6'h36
`define SBR_STATUS_PAD 7'h00
// write pulse timing
`define SBR_CLK_PERIOD_NS 25
`define SBR_WR_MIN_NS 120
`define SBR_WR_MIN_CYC ((`SBR_WR_MIN_NS + `SBR_CLK_PERIOD_NS - 1) / `SBR_CLK_PERIOD_NS)
`define SBR_LOWCNT_W 3
`define SBR_LOWCNT_MAX 3'h7

`endif

// *** hw/sbr_sector_buffer.sv ***
/*
  sector buffer ram with its presettable post-decrementing address counter,
  port strobe decode, count exhausted status and the function control port.
  assumes the processor logic runs on the same clock, pulses i_instr_start at
  the first cycle of each instruction and drives the write phase and bus.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sbr_regs.svh"

// Summary of operation
// RULE_01: ten-bit address selects one of 1024 bytes
// RULE_02: processor port writes preset the address counters
// RULE_03: zero stage borrows, next stage decrements later; code decrements it on the same clock edge as the zero stage wraps
// RULE_04: all-zero address drives exhausted status low, readable
// RULE_05: preset start address bounds loops, 1 to 1024
// RULE_06: processor picks 128, 256 or 512 lengths
// RULE_07: address decrements only after access completes
// RULE_08: buffer select is OR of port0 strobes
// RULE_09: ram drives bus when selected in read phase
// RULE_10: ram stores bus byte at write phase end
// RULE_11: write phase and select low at least 120 ns
// RULE_12: presettable counters allow random scratchpad access
// RULE_13: random access two or three cycles, sequential one
// RULE_14: six-bit function control port with named bits
// RULE_15: function port latches only on port7 write
// RULE_16: function write also loads address bits nine, eight
// RULE_17: per-instruction select field decodes port strobes
// RULE_18: address holds when no access and no preset

module sbr_sector_buffer
  import sbr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_instr_start,
  input wire sbr_fio_sel_t i_fast_io_sel,
  input wire logic i_processor_write_phase_n,
  input wire logic [`SBR_DATA_W-1:0] i_port_bus,
  output logic [`SBR_DATA_W-1:0] o_port_bus,
  output logic o_port_bus_oe,
  output logic o_port0_read_strobe_n,
  output logic o_port0_write_strobe_n,
  output logic o_port7_write_strobe,
  output logic o_buffer_select_n,
  output logic [`SBR_ADDR_W-1:0] o_buffer_address_bits,
  output logic o_buffer_count_exhausted_n,
  output sbr_func_ctl_t o_function_control_port,
  output logic [`SBR_DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic o_read_stall,
  output logic o_write_short
);

  logic [`SBR_DATA_W-1:0] mem [0:`SBR_RAM_DEPTH-1];
  sbr_fio_sel_t fio_r;
  logic fio_valid_r;
  logic rd_ok_r;
  logic wp_q_r;
  logic wr_trail;
  logic rd_phase;
  logic wr_phase;
  logic rd_any_n;
  logic wr_any;
  logic [2:0] wr_port_r;
  logic wr_was_r;
  logic [`SBR_DATA_W-1:0] wdata_r;
  logic [`SBR_LOWCNT_W-1:0] lowcnt_r;
  logic ram_we;
  logic load_lo;
  logic load_hi;
  logic load_any;
  logic [`SBR_DATA_W-1:0] port_q_r;
  logic exh_r;
  logic short_r;
  sbr_func_ctl_t func_r;
  sbr_state_t st_r;
  sbr_state_t st_nxt;
  logic dec;
  logic rd0_q_r;
  logic rd0_rise;
  logic push_ready;
  logic stall_r;
  logic [`SBR_ADDR_W-1:0] addr;
  logic b0;
  logic b1;
  logic [`SBR_STG0_W-1:0] c0;
  logic [`SBR_STG1_W-1:0] c1;
  logic [`SBR_STG2_W-1:0] c2;

  // the select field is latched for the whole instruction
  // RULE_17: latch select field
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      fio_r <= '0;
      fio_valid_r <= 1'b0;
    end
    else if (i_instr_start)
    begin
      fio_r <= i_fast_io_sel;
      fio_valid_r <= 1'b1;
    end
  end

  // read half ends at the write phase, so one instruction is one access
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      rd_ok_r <= 1'b0;
    else if (i_instr_start)
      rd_ok_r <= 1'b1;
    else if (!i_processor_write_phase_n)
      rd_ok_r <= 1'b0;
  end

  // read decode is disqualified at instruction turnover to keep strobe edges
  assign rd_phase = fio_valid_r && rd_ok_r && i_processor_write_phase_n && !i_instr_start;
  assign wr_phase = fio_valid_r && !i_processor_write_phase_n;
  // RULE_17: decode port strobes
  assign o_port0_read_strobe_n = !(rd_phase && (fio_r.rd == `SBR_PORT_RAM));
  assign o_port0_write_strobe_n = !(wr_phase && (fio_r.wr == `SBR_PORT_RAM));
  assign o_port7_write_strobe = wr_phase && (fio_r.wr == `SBR_PORT_FUNC);
  // RULE_08: select is strobe OR
  assign o_buffer_select_n = o_port0_read_strobe_n && o_port0_write_strobe_n;
  assign rd_any_n = !(rd_phase && ((fio_r.rd == `SBR_PORT_RAM) || (fio_r.rd == `SBR_PORT_STATUS)));
  // RULE_09: drive bus in read phase
  assign o_port_bus_oe = !rd_any_n;
  assign o_port_bus = port_q_r;
  assign wr_any = wr_phase;

  // trailing edge of the write phase closes every port write
  assign wr_trail = !wp_q_r && i_processor_write_phase_n;

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wp_q_r <= 1'b1;
      wr_was_r <= 1'b0;
      wr_port_r <= 3'h0;
      wdata_r <= '0;
    end
    else
    begin
      wp_q_r <= i_processor_write_phase_n;
      wr_was_r <= wr_any;
      if (wr_any)
      begin
        wr_port_r <= fio_r.wr;
        wdata_r <= i_port_bus;
      end
    end
  end

  // RULE_11: count overlap of phase and select
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      lowcnt_r <= '0;
    else if (!o_buffer_select_n && !i_processor_write_phase_n)
    begin
      if (lowcnt_r != `SBR_LOWCNT_MAX)
        lowcnt_r <= lowcnt_r + `SBR_LOWCNT_W'(1);
    end
    else
      lowcnt_r <= '0;
  end

  // a pulse shorter than the setup window is refused, not stored half-set
  // RULE_10: store at trailing edge
  assign ram_we = wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_RAM)
                  && (lowcnt_r >= `SBR_LOWCNT_W'(`SBR_WR_MIN_CYC));

  always_ff @(posedge i_clk)
  begin
    if (ram_we)
      mem[addr] <= wdata_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      short_r <= 1'b0;
    else
      short_r <= wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_RAM) && !ram_we;
  end
  assign o_write_short = short_r;

  // RULE_15: latch on port7 write
  // RULE_14: six function bits
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      func_r <= `SBR_FUNC_RESET;
    else if (wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_FUNC))
      func_r <= wdata_r[`SBR_FUNC_MSB:`SBR_FUNC_LSB];
  end
  assign o_function_control_port = func_r;

  // RULE_02: preset from port writes
  assign load_lo = wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_ADDR_LO);
  // RULE_16: function write loads upper bits
  assign load_hi = wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_FUNC);
  assign load_any = load_lo || load_hi;

  // the address is already stable from the previous instruction, so the
  // registered read needs no extra wait cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      port_q_r <= '0;
    else if (fio_r.rd == `SBR_PORT_STATUS)
      port_q_r <= {`SBR_STATUS_PAD, exh_r};
    else
      port_q_r <= mem[addr];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      rd0_q_r <= 1'b0;
    else
      rd0_q_r <= !o_port0_read_strobe_n;
  end
  assign rd0_rise = !o_port0_read_strobe_n && !rd0_q_r;

  // a full buffer refuses the read: no push and no decrement, so software
  // retries the same byte instead of losing it
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      stall_r <= 1'b0;
    else
      stall_r <= rd0_rise && !push_ready;
  end
  assign o_read_stall = stall_r;

  sbr_two_buf #(.WIDTH(`SBR_DATA_W)) u_rd_buf (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(rd0_rise),
    .i_in_data(port_q_r),
    .o_in_ready(push_ready),
    .o_out_valid(o_rd_valid),
    .o_out_data(o_rd_data),
    .i_out_ready(i_rd_ready)
  );

  // RULE_07: decrement after access ends
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      SBR_ST_IDLE:
        if (!o_buffer_select_n)
          st_nxt = (rd0_rise && !push_ready) ? SBR_ST_HELD : SBR_ST_ACCESS;
      SBR_ST_ACCESS:
        if (o_buffer_select_n)
          st_nxt = SBR_ST_DONE;
      SBR_ST_DONE:
        st_nxt = SBR_ST_IDLE;
      SBR_ST_HELD:
        if (o_buffer_select_n)
          st_nxt = SBR_ST_IDLE;
      default:
        st_nxt = SBR_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      st_r <= SBR_ST_IDLE;
    else
      st_r <= st_nxt;
  end

  // RULE_18: only completed accesses count
  assign dec = (st_r == SBR_ST_DONE) && !load_any;

  // RULE_03: cascaded borrow chain
  sbr_count_stage #(.W(`SBR_STG0_W)) u_stg0 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(load_lo),
    .i_load_val(wdata_r[`SBR_STG0_W-1:0]),
    .i_dec(dec),
    .i_borrow_in(1'b1),
    .o_count(c0),
    .o_borrow_out(b0)
  );

  sbr_count_stage #(.W(`SBR_STG1_W)) u_stg1 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(load_lo),
    .i_load_val(wdata_r[`SBR_DATA_W-1:`SBR_STG0_W]),
    .i_dec(dec),
    .i_borrow_in(b0),
    .o_count(c1),
    .o_borrow_out(b1)
  );

  sbr_count_stage #(.W(`SBR_STG2_W)) u_stg2 (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_load(load_hi),
    .i_load_val(wdata_r[`SBR_UPPER_MSB:`SBR_UPPER_LSB]),
    .i_dec(dec),
    .i_borrow_in(b1),
    .o_count(c2),
    .o_borrow_out()
  );

  // RULE_01: ten-bit address
  assign addr = {c2, c1, c0};
  assign o_buffer_address_bits = addr;

  // RULE_04: exhausted status, readable
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
      exh_r <= 1'b0;
    else
      exh_r <= (addr != `SBR_ADDR_ZERO);
  end
  assign o_buffer_count_exhausted_n = exh_r;

  sequence s_access_end;
    (st_r == SBR_ST_ACCESS) ##1 (st_r == SBR_ST_DONE);
  endsequence

  sequence s_port_write(logic [2:0] port);
    (wr_phase && (fio_r.wr == port)) ##1 (wr_trail && (wr_port_r == port));
  endsequence

  AST_DEC_AFTER_ACCESS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_07
    s_access_end ##0 !load_any |=> (addr == $past(addr) - 10'h001))
    else $error("address did not step down after access");

  AST_HOLD_NO_ACCESS: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_18
    (st_r != SBR_ST_DONE) && !load_any |=> $stable(addr))
    else $error("address moved without access");

  AST_BORROW_WRAP: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_03
    dec && (c0 == 4'h0) && (addr != `SBR_ADDR_ZERO) |=> (c0 == 4'hf) && (c1 == $past(c1) - 4'h1
      || $past(c1) == 4'h0))
    else $error("borrow did not reach next stage");

  AST_EXHAUSTED_LOW: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_04
    (addr == `SBR_ADDR_ZERO) ##1 $stable(addr) |-> !o_buffer_count_exhausted_n)
    else $error("exhausted status not low at zero");

  AST_LOOP_END: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_05
    dec && (addr == 10'h001) |=> ##1 !o_buffer_count_exhausted_n)
    else $error("loop did not end at zero");

  AST_SELECT_OR: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_08
    (!o_port0_read_strobe_n || !o_port0_write_strobe_n) |-> !o_buffer_select_n)
    else $error("select missing during port0 strobe");

  AST_BUS_DRIVE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_09
    !o_buffer_select_n && i_processor_write_phase_n |-> o_port_bus_oe)
    else $error("ram not driving bus in read phase");

  AST_RAM_STORE: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_10
    ram_we ##1 (fio_r.rd == `SBR_PORT_RAM) && $stable(addr) |=> (port_q_r == $past(wdata_r, 2)))
    else $error("stored byte not read back");

  AST_WRITE_WIDTH: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_11
    ram_we |-> $past(!o_buffer_select_n && !i_processor_write_phase_n, 5))
    else $error("write pulse shorter than setup window");

  AST_FUNC_ONLY_PORT7: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_15
    !(wr_trail && wr_was_r && (wr_port_r == `SBR_PORT_FUNC)) |=> $stable(func_r))
    else $error("function port changed without port7 write");

  AST_UPPER_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_16
    s_port_write(`SBR_PORT_FUNC) ##0 wr_was_r |=> (c2 == $past(wdata_r[`SBR_UPPER_MSB:`SBR_UPPER_LSB]))
      && (func_r == $past(wdata_r[`SBR_FUNC_MSB:`SBR_FUNC_LSB])))
    else $error("function write did not load upper address");

  AST_PRESET_LOW: assert property (@(posedge i_clk) disable iff (!i_reset_n) // RULE_12
    s_port_write(`SBR_PORT_ADDR_LO) ##0 wr_was_r |=> (addr[`SBR_DATA_W-1:0] == $past(wdata_r)))
    else $error("preset did not load address");

endmodule

`default_nettype wire

// *** hw/sbr_two_buf.sv ***
/*
  two-entry buffer with valid and ready on both sides.
  assumes the filling side holds its word until ready is seen.
*/
`timescale 1ns/10ps
`default_nettype none

module sbr_two_buf
#(
  parameter int WIDTH = 8
)
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  logic [WIDTH-1:0] slot_r [0:1];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] fill_r;
  logic push;
  logic pop;

  assign o_in_ready = (fill_r != 2'h2);
  assign o_out_valid = (fill_r != 2'h0);
  assign o_out_data = slot_r[rptr_r];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (push)
      slot_r[wptr_r] <= i_in_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      fill_r <= 2'h0;
    end
    else
    begin
      if (push)
        wptr_r <= ~wptr_r;
      if (pop)
        rptr_r <= ~rptr_r;
      if (push && !pop)
        fill_r <= fill_r + 2'h1;
      else if (pop && !push)
        fill_r <= fill_r - 2'h1;
    end
  end

endmodule

`default_nettype wire

// *** verification/sbr_proc_model.sv ***
/*
  behavioural model of the on-board processor driving the sector buffer:
  instruction start, port select field, write phase and port bus.
  assumes one clock shared with the block; the bench calls instr() by path.
*/
`timescale 1ns/10ps
`default_nettype none

module sbr_proc_model
  import sbr_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_port_bus,
  input wire logic i_port_bus_oe,
  input wire logic i_buffer_select_n,
  input wire logic i_port7_write_strobe,
  input wire logic i_read_stall,
  input wire logic i_write_short,
  output logic o_instr_start,
  output sbr_fio_sel_t o_fast_io_sel,
  output logic o_write_phase_n,
  output logic [7:0] o_port_bus
);
  logic [7:0] rd_byte;
  logic rd_sel_n;
  logic rd_oe;
  logic wr_sel_n;
  logic wr_p7;
  logic got_stall;
  logic got_short;

  initial
  begin
    o_instr_start = 1'b0;
    o_fast_io_sel = sbr_fio_sel_t'(6'h1b);
    o_write_phase_n = 1'b1;
    o_port_bus = 8'h00;
    got_stall = 1'b0;
    got_short = 1'b0;
  end

  // pulses only last a cycle, so latch them
  always @(posedge i_clk)
  begin
    if (i_read_stall)
      got_stall <= 1'b1;
    if (i_write_short)
      got_short <= 1'b1;
  end

  // one instruction, read half then write half
  task automatic instr(input logic [2:0] rd, input logic [2:0] wr, input logic [7:0] data, input int wlen);
    got_stall = 1'b0;
    got_short = 1'b0;
    @(posedge i_clk);
    o_instr_start <= 1'b1;
    o_fast_io_sel <= sbr_fio_sel_t'({rd, wr});
    @(posedge i_clk);
    o_instr_start <= 1'b0;
    repeat (3) @(posedge i_clk);
    rd_byte = i_port_bus;
    rd_sel_n = i_buffer_select_n;
    rd_oe = i_port_bus_oe;
    o_write_phase_n <= 1'b0;
    o_port_bus <= data;
    repeat (wlen) @(posedge i_clk);
    wr_sel_n = i_buffer_select_n;
    wr_p7 = i_port7_write_strobe;
    // write phase released; bus flipped to the inverted byte, so no stale byte is left on it
    o_write_phase_n <= 1'b1;
    o_port_bus <= ~data;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
/*
  self-checking bench of the sector buffer ram addressing block.
  assumes the processor model drives the instruction side; bench owns reset
  and the read buffer consumer.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    cmp_count++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic rd_ready = 1'b1;
  logic instr_start;
  sbr_pkg::sbr_fio_sel_t fio_sel;
  logic phase_n;
  logic [7:0] bus_in;
  logic [7:0] bus_out;
  logic bus_oe;
  logic sel_n;
  logic p0w_n;
  logic p7w;
  logic [9:0] addr;
  logic exhausted_n;
  sbr_pkg::sbr_func_ctl_t func;
  logic [7:0] rd_data;
  logic rd_valid;
  logic stall;
  logic wshort;
  logic [5:0] func_v = 6'h36;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #12.5 clk = ~clk;

  sbr_sector_buffer sbr_sector_buffer_i (.i_clk(clk), .i_reset_n(reset_n), .i_instr_start(instr_start),
    .i_fast_io_sel(fio_sel), .i_processor_write_phase_n(phase_n), .i_port_bus(bus_in),
    .o_port_bus(bus_out), .o_port_bus_oe(bus_oe), .o_port0_read_strobe_n(), .o_port0_write_strobe_n(p0w_n),
    .o_port7_write_strobe(p7w), .o_buffer_select_n(sel_n), .o_buffer_address_bits(addr),
    .o_buffer_count_exhausted_n(exhausted_n), .o_function_control_port(func), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_read_stall(stall), .o_write_short(wshort));

  sbr_proc_model sbr_proc_model_i (.i_clk(clk), .i_port_bus(bus_out), .i_port_bus_oe(bus_oe),
    .i_buffer_select_n(sel_n), .i_port7_write_strobe(p7w), .i_read_stall(stall), .i_write_short(wshort),
    .o_instr_start(instr_start), .o_fast_io_sel(fio_sel), .o_write_phase_n(phase_n), .o_port_bus(bus_in));

  task automatic preset(input logic [9:0] a);
    sbr_proc_model_i.instr(3'h3, 3'h7, {func_v, a[9:8]}, 6);
    sbr_proc_model_i.instr(3'h3, 3'h1, a[7:0], 6);
  endtask

  task automatic wr_byte(input logic [7:0] d);
    sbr_proc_model_i.instr(3'h3, 3'h0, d, 6);
  endtask

  task automatic rd_mem(input logic [2:0] port, output logic [7:0] d);
    sbr_proc_model_i.instr(port, 3'h3, 8'h00, 6);
    d = sbr_proc_model_i.rd_byte;
  endtask

  task automatic t_reset();
    `CHK(addr, 10'h000)
    `CHK(exhausted_n, 1'b0)
    `CHK(func, 6'h36)
    `CHK(bus_oe, 1'b0)
    `CHK(rd_valid, 1'b0)
  endtask

  task automatic t_func_port();
    func_v = 6'h2b;
    preset(10'h2c5);
    `CHK(sbr_proc_model_i.wr_p7, 1'b0)
    `CHK(func, func_v)
    `CHK(addr, 10'h2c5)
    sbr_proc_model_i.instr(3'h3, 3'h5, 8'hff, 6);
    `CHK(func, func_v)
    `CHK(addr, 10'h2c5)
  endtask

  task automatic t_borrow();
    logic [7:0] d;
    preset(10'h100);
    rd_mem(3'h2, d);
    `CHK(d, 8'h01)
    wr_byte(8'ha5);
    `CHK(sbr_proc_model_i.wr_sel_n, 1'b0)
    `CHK(sbr_proc_model_i.got_short, 1'b0)
    `CHK(addr, 10'h0ff)
    preset(10'h100);
    rd_mem(3'h0, d);
    `CHK(d, 8'ha5)
    `CHK(sbr_proc_model_i.rd_sel_n, 1'b0)
    `CHK(sbr_proc_model_i.rd_oe, 1'b1)
    `CHK(sbr_proc_model_i.wr_sel_n, 1'b1)
    `CHK(addr, 10'h0ff)
    sbr_proc_model_i.instr(3'h3, 3'h3, 8'h00, 6);
    `CHK(addr, 10'h0ff)
  endtask

  task automatic t_loops();
    int lens[4];
    int n;
    logic [7:0] d;
    lens = '{1, 128, 256, 512};
    foreach (lens[k])
    begin
      preset(10'(lens[k] - 1));
      n = 0;
      while (exhausted_n !== 1'b0 && n < 1024)
      begin
        wr_byte(8'(n));
        n++;
      end
      `CHK(n, lens[k] - 1)
      `CHK(addr, 10'h000)
    end
    rd_mem(3'h2, d);
    `CHK(d, 8'h00)
  endtask

  // random access: preset then one access
  task automatic t_scratch();
    logic [7:0] d;
    preset(10'h1fe);
    rd_mem(3'h0, d);
    `CHK(d, 8'h01)
    preset(10'h050);
    sbr_proc_model_i.instr(3'h3, 3'h0, 8'h3c, 2);
    `CHK(sbr_proc_model_i.got_short, 1'b1)
    preset(10'h050);
    rd_mem(3'h0, d);
    `CHK(d, 8'haf)
  endtask

  // stalled consumer: third read must be refused, not lost
  task automatic t_buffer();
    logic [7:0] d;
    @(posedge clk);
    rd_ready <= 1'b0;
    preset(10'h003);
    rd_mem(3'h0, d);
    `CHK(sbr_proc_model_i.got_stall, 1'b0)
    rd_mem(3'h0, d);
    `CHK(sbr_proc_model_i.got_stall, 1'b0)
    rd_mem(3'h0, d);
    `CHK(sbr_proc_model_i.got_stall, 1'b1)
    sbr_proc_model_i.instr(3'h3, 3'h3, 8'h00, 6);
    `CHK(addr, 10'h001)
    `CHK(rd_data, 8'hfc)
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    @(posedge clk);
    `CHK(rd_data, 8'hfd)
    `CHK(rd_valid, 1'b1)
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
    @(posedge clk);
    `CHK(rd_valid, 1'b0)
    rd_ready <= 1'b1;
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // about 17 cycles an instruction, under 1000 instructions
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_func_port();
    t_borrow();
    t_loops();
    t_scratch();
    t_buffer();
    summarize();
  end
endmodule

`default_nettype wire
